// File: erf_top.sv
// rx flag, station address and configuration word block on AHB-Lite
// assumes one slave on the bus, hready looped back from hreadyout;
// event strobes, factory address and configuration word from hclk logic
`timescale 1ns/10ps
`include "erf_defines.svh"

// Function
// RULE1: descriptor overrun strobe sets interrupt request bit 1.
// RULE2: bit 1 clears only on reset or a one written via clear alias; code also clears it by a zero via write alias or a one via invert alias.
// RULE3: receive fifo overflow strobe sets interrupt request bit 0.
// RULE4: bit 0 clears only on reset or a one written via clear alias; code also clears it by a zero via write alias or a one via invert alias.
// RULE5: software should change request bits only through the alias registers.
// RULE6: station address holds first octet in bits 7-0, second in 15-8.
// RULE7: software writes zero to address bits 31-16 and ignores their read value.
// RULE8: station address and aliases take 16 and 32 bit access; byte access ignored.
// RULE9: station address loads from factory address after reset, not a constant.
// RULE10: configuration bit 24 one selects MII, zero selects RMII.
// RULE11: configuration bit 25 one selects default pins, zero alternate pins.
// RULE12: parts without alternate pins ignore bit 25 and use default pins.
// RULE13: software writes ones to reserved configuration bits 31, 26, 23-16.
// RULE14: clear alias clears only bits written one, others stay.
module erf_top #(
    parameter bit HAS_ALT_PINS = 1'b1
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [2:0]  hburst,
    input  wire logic [3:0]  hprot,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        rx_descriptor_overrun,
    input  wire logic        rx_fifo_overflow,
    input  wire logic [15:0] factory_station_addr,
    input  wire logic [31:0] config_word_in,
    output logic             rx_descriptor_unavailable_flag,
    output logic             rx_fifo_overflow_flag,
    output logic [7:0]       first_address_octet,
    output logic [7:0]       second_address_octet,
    output logic             phy_interface_select,
    output logic             eth_pin_set_select
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic                          boot_done_reg;
    logic                          dp_valid_reg;
    logic                          dp_write_reg;
    logic [`ERF_OFS_WIDTH-1:0]     dp_addr_reg;
    logic [2:0]                    dp_size_reg;
    logic [31:0]                   hrdata_reg;
    logic [31:0]                   device_configuration_word_three_reg;
    logic                          phy_interface_select_reg;
    logic                          eth_pin_set_select_reg;
    logic                          hreadyout_reg;
    logic                          hresp_reg;

    // ****************************************************************
    // address phase
    // ****************************************************************
    logic                          addr_phase;
    logic                          addr_read;
    logic [3:0]                    ap_group;
    logic                          ap_is_byte;
    logic                          boot_load;

    assign addr_phase = hsel & htrans[1] & hready;
    assign addr_read  = addr_phase & ~hwrite;
    assign ap_group   = haddr[7:4];
    assign ap_is_byte = (hsize == `ERF_HSIZE_BYTE);
    assign boot_load  = ~boot_done_reg;

    // ****************************************************************
    // data phase decode
    // ****************************************************************
    logic [3:0]                    dp_group;
    logic [1:0]                    dp_alias_code;
    erf_pkg::erf_alias_t           dp_op;
    logic                          dp_is_byte;
    logic                          dp_is_half;
    logic [3:0]                    dp_byte_lanes;
    logic [3:0]                    dp_lanes;
    logic                          dp_wr;
    logic                          irq_we;
    logic                          sa_we;
    logic [`ERF_SA_WIDTH-1:0]      sa_mask;

    assign dp_group      = dp_addr_reg[7:4];
    assign dp_alias_code = dp_addr_reg[3:2];
    assign dp_op = (dp_alias_code == `ERF_ALIAS_CLR_CODE) ? erf_pkg::ERF_ALIAS_CLR :
                   (dp_alias_code == `ERF_ALIAS_SET_CODE) ? erf_pkg::ERF_ALIAS_SET :
                   (dp_alias_code == `ERF_ALIAS_INV_CODE) ? erf_pkg::ERF_ALIAS_INV :
                                                            erf_pkg::ERF_ALIAS_WRITE;
    assign dp_is_byte    = (dp_size_reg == `ERF_HSIZE_BYTE);
    assign dp_is_half    = (dp_size_reg == `ERF_HSIZE_HALF);
    assign dp_byte_lanes = (dp_addr_reg[1:0] == 2'h0) ? 4'h1 :
                           (dp_addr_reg[1:0] == 2'h1) ? 4'h2 :
                           (dp_addr_reg[1:0] == 2'h2) ? 4'h4 : 4'h8;
    assign dp_lanes      = dp_is_byte ? dp_byte_lanes :
                           dp_is_half ? (dp_addr_reg[1] ? 4'hc : 4'h3) : 4'hf;
    assign dp_wr         = dp_valid_reg & dp_write_reg;

    // flags live in lane 0; any access size reaching it applies
    assign irq_we  = dp_wr & (dp_group == `ERF_GRP_IRQ) & dp_lanes[0];

    // byte writes dropped; upper half of the word is reserved and inert
    assign sa_we   = dp_wr & (dp_group == `ERF_GRP_SA) & ~dp_is_byte
                     & (dp_lanes[0] | dp_lanes[1]); // RULE8
    assign sa_mask = {{8{dp_lanes[1]}}, {8{dp_lanes[0]}}}; // RULE8 RULE7

    // ****************************************************************
    // interrupt request flags
    // ****************************************************************
    logic                          bufna_q;
    logic                          bufna_next;
    logic                          ovflw_q;
    logic                          ovflw_next;

    erf_flag_bit u_bufna_flag (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hw_set    (rx_descriptor_overrun), // RULE1
        .sw_we     (irq_we), // RULE2 RULE14
        .sw_op     (dp_op),
        .sw_wd     (hwdata[`ERF_IRQ_BUFNA_BIT]),
        .flag_q    (bufna_q),
        .flag_next (bufna_next)
    );

    erf_flag_bit u_ovflw_flag (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hw_set    (rx_fifo_overflow), // RULE3
        .sw_we     (irq_we), // RULE4 RULE14
        .sw_op     (dp_op),
        .sw_wd     (hwdata[`ERF_IRQ_OVFLW_BIT]),
        .flag_q    (ovflw_q),
        .flag_next (ovflw_next)
    );

    assign rx_descriptor_unavailable_flag = bufna_q;
    assign rx_fifo_overflow_flag          = ovflw_q;

    // ****************************************************************
    // station address octets one and two
    // ****************************************************************
    logic [`ERF_SA_WIDTH-1:0]      station_address_octets_one_two;
    logic [`ERF_SA_WIDTH-1:0]      sa_next;

    erf_alias_reg #(
        .WIDTH (`ERF_SA_WIDTH)
    ) u_station_addr (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .load     (boot_load), // RULE9
        .load_val (factory_station_addr), // RULE9
        .we       (sa_we),
        .op       (dp_op),
        .wdata    (hwdata[`ERF_SA_WIDTH-1:0]),
        .wmask    (sa_mask),
        .q        (station_address_octets_one_two),
        .q_next   (sa_next)
    );

    assign first_address_octet  = station_address_octets_one_two[`ERF_SA_OCT1_LSB +: 8]; // RULE6
    assign second_address_octet = station_address_octets_one_two[`ERF_SA_OCT2_LSB +: 8]; // RULE6

    // ****************************************************************
    // configuration word capture and pin steering
    // ****************************************************************
    logic                          cfg_mii_next;
    logic                          cfg_pinset_next;

    assign cfg_mii_next    = config_word_in[`ERF_CFG_MII_BIT]; // RULE10
    assign cfg_pinset_next = HAS_ALT_PINS ? config_word_in[`ERF_CFG_PINSET_BIT]
                                          : 1'b1; // RULE11 RULE12

    // word sampled once, on the first edge after reset release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_done_reg                       <= 1'b0;
            device_configuration_word_three_reg <= `ERF_CFG_RST;
            phy_interface_select_reg            <= 1'b1;
            eth_pin_set_select_reg              <= 1'b1;
        end else if (boot_load) begin
            boot_done_reg                       <= 1'b1;
            device_configuration_word_three_reg <= config_word_in;
            phy_interface_select_reg            <= cfg_mii_next; // RULE10
            eth_pin_set_select_reg              <= cfg_pinset_next; // RULE11 RULE12
        end
    end

    assign phy_interface_select = phy_interface_select_reg;
    assign eth_pin_set_select   = eth_pin_set_select_reg;

    // ****************************************************************
    // read data, taken from next values so a write just before is seen
    // ****************************************************************
    logic [31:0]                   rd_irq;
    logic [31:0]                   rd_sa;
    logic [31:0]                   rd_cfg;
    logic [31:0]                   rd_word;

    assign rd_irq  = {30'h00000000, bufna_next, ovflw_next};
    assign rd_sa   = ap_is_byte ? 32'h00000000
                                : {16'h0000, sa_next}; // RULE8 RULE7
    assign rd_cfg  = boot_load ? config_word_in : device_configuration_word_three_reg;
    assign rd_word = (ap_group == `ERF_GRP_IRQ) ? rd_irq :
                     (ap_group == `ERF_GRP_SA)  ? rd_sa  :
                     (ap_group == `ERF_GRP_CFG) ? rd_cfg : 32'h00000000;

    // ****************************************************************
    // bus pipeline
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg  <= 8'h00;
            dp_size_reg  <= 3'h0;
        end else if (hready) begin
            dp_valid_reg <= addr_phase;
            dp_write_reg <= hwrite;
            dp_addr_reg  <= haddr[`ERF_OFS_WIDTH-1:0];
            dp_size_reg  <= hsize;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h00000000;
        end else if (addr_read) begin
            hrdata_reg <= rd_word;
        end
    end

    // zero wait states: always ready once out of reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= `ERF_HRESP_OKAY;
        end else begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= `ERF_HRESP_OKAY;
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hresp     = hresp_reg;
    assign hrdata    = hrdata_reg;

endmodule

// File: erf_defines.svh
// offsets, field positions, reset values and codes of the rx flag block
// assumes inclusion by bare name from each design file that needs it
`ifndef ERF_DEFINES_SVH
`define ERF_DEFINES_SVH

// ****************************************************************
// address map: group in byte address bits 7:4, alias in bits 3:2
// ****************************************************************
`define ERF_OFS_WIDTH          8
`define ERF_GRP_IRQ            4'h0
`define ERF_GRP_SA             4'h1
`define ERF_GRP_CFG            4'h2
`define ERF_ALIAS_WRITE_CODE   2'h0
`define ERF_ALIAS_CLR_CODE     2'h1
`define ERF_ALIAS_SET_CODE     2'h2
`define ERF_ALIAS_INV_CODE     2'h3

// ****************************************************************
// field positions
// ****************************************************************
`define ERF_IRQ_OVFLW_BIT      0
`define ERF_IRQ_BUFNA_BIT      1
`define ERF_SA_WIDTH           16
`define ERF_SA_OCT1_LSB        0
`define ERF_SA_OCT2_LSB        8
`define ERF_CFG_MII_BIT        24
`define ERF_CFG_PINSET_BIT     25

// ****************************************************************
// reset values
// ****************************************************************
`define ERF_SA_RST             16'h0000
`define ERF_CFG_RST            32'hffffffff
`define ERF_FLAG_RST           1'b0

// ****************************************************************
// bus codes
// ****************************************************************
`define ERF_HSIZE_BYTE         3'h0
`define ERF_HSIZE_HALF         3'h1
`define ERF_HRESP_OKAY         1'b0

`endif

// File: erf_pkg.sv
// types shared by the rx flag block
// assumes nothing beyond a SystemVerilog compiler
package erf_pkg;

    // ****************************************************************
    // software operation selected by the alias address
    // ****************************************************************
    typedef enum logic [1:0] {
        ERF_ALIAS_WRITE,
        ERF_ALIAS_CLR,
        ERF_ALIAS_SET,
        ERF_ALIAS_INV
    } erf_alias_t;

endpackage

// File: erf_flag_bit.sv
// one sticky event flag with write, clear, set and invert aliases
// assumes set and software strobes come from logic on hclk
`timescale 1ns/10ps
`include "erf_defines.svh"

module erf_flag_bit (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hw_set,
    input  wire logic               sw_we,
    input  wire erf_pkg::erf_alias_t sw_op,
    input  wire logic               sw_wd,
    output logic                    flag_q,
    output logic                    flag_next
);

    logic sw_val;

    // per bit: a zero written through clear, set or invert changes nothing
    assign sw_val = (sw_op == erf_pkg::ERF_ALIAS_WRITE) ? sw_wd :
                    (sw_op == erf_pkg::ERF_ALIAS_CLR)   ? (flag_q & ~sw_wd) :
                    (sw_op == erf_pkg::ERF_ALIAS_SET)   ? (flag_q | sw_wd) :
                                                          (flag_q ^ sw_wd);

    // hardware event beats any software change in the same cycle
    assign flag_next = hw_set ? 1'b1 : (sw_we ? sw_val : flag_q);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_q <= `ERF_FLAG_RST;
        end else begin
            flag_q <= flag_next;
        end
    end

endmodule

// File: erf_alias_reg.sv
// software register with write, clear, set and invert aliases and a load port
// assumes lane mask and load come from logic on hclk
`timescale 1ns/10ps
`include "erf_defines.svh"

module erf_alias_reg #(
    parameter int WIDTH = `ERF_SA_WIDTH
) (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               load,
    input  wire logic [WIDTH-1:0]   load_val,
    input  wire logic               we,
    input  wire erf_pkg::erf_alias_t op,
    input  wire logic [WIDTH-1:0]   wdata,
    input  wire logic [WIDTH-1:0]   wmask,
    output logic [WIDTH-1:0]        q,
    output logic [WIDTH-1:0]        q_next
);

    logic [WIDTH-1:0] op_val;
    logic [WIDTH-1:0] masked_val;

    assign op_val = (op == erf_pkg::ERF_ALIAS_WRITE) ? wdata :
                    (op == erf_pkg::ERF_ALIAS_CLR)   ? (q & ~wdata) :
                    (op == erf_pkg::ERF_ALIAS_SET)   ? (q | wdata) :
                                                       (q ^ wdata);

    // lanes outside the access keep their value
    assign masked_val = (op_val & wmask) | (q & ~wmask);

    assign q_next = load ? load_val : (we ? masked_val : q);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= WIDTH'(`ERF_SA_RST);
        end else begin
            q <= q_next;
        end
    end

endmodule

// File: erf_rx_source.sv
// behavioural receive logic and fuse store feeding the rx flag block
// assumes requests from the bench on hclk and config changes only in reset
`timescale 1ns/10ps

module erf_rx_source #(
    parameter logic [15:0] FACTORY_ADDR = 16'h5ac3
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ovf_req,
    input  wire logic        dov_req,
    input  wire logic        alt_cfg,
    output logic             rx_fifo_overflow,
    output logic             rx_descriptor_overrun,
    output logic [15:0]      factory_station_addr,
    output logic [31:0]      config_word_in
);
    // ****************************************************************
    // event strobes and fuse values
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_fifo_overflow      <= 1'b0;
            rx_descriptor_overrun <= 1'b0;
        end else begin
            rx_fifo_overflow      <= ovf_req;
            rx_descriptor_overrun <= dov_req;
        end
    end
    // second fuse set inverts every address bit and flips config bits 25-24, so reload is visible
    assign factory_station_addr = alt_cfg ? ~FACTORY_ADDR : FACTORY_ADDR;
    assign config_word_in       = {alt_cfg ? 8'hb4 : 8'hb7, 8'hff, 16'h1234};
endmodule

// File: erf_checker_assertions.sv
// concurrent checks on the ports of the rx flag block
// assumes hready looped from hreadyout and one clock domain
`timescale 1ns/10ps
`include "erf_defines.svh"

module erf_checker #(
    parameter bit HAS_ALT_PINS = 1'b1
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        rx_descriptor_overrun,
    input wire logic        rx_fifo_overflow,
    input wire logic [15:0] factory_station_addr,
    input wire logic [31:0] config_word_in,
    input wire logic        rx_descriptor_unavailable_flag,
    input wire logic        rx_fifo_overflow_flag,
    input wire logic [7:0]  first_address_octet,
    input wire logic [7:0]  second_address_octet,
    input wire logic        phy_interface_select,
    input wire logic        eth_pin_set_select
);
    // ****************************************************************
    // data phase tracking
    // ****************************************************************
    logic        wr_pend, rd_pend, irq_wr, clear_wr, cfg_mii, cfg_pin;
    logic [7:0]  addr_q;
    logic [2:0]  size_q;
    logic [15:0] sa_now;
    assign sa_now   = {second_address_octet, first_address_octet};
    assign irq_wr   = wr_pend && (addr_q[7:4] == `ERF_GRP_IRQ);
    assign clear_wr = irq_wr && (addr_q[3:2] == 2'h1);
    assign cfg_mii  = config_word_in[`ERF_CFG_MII_BIT];
    assign cfg_pin  = HAS_ALT_PINS ? config_word_in[`ERF_CFG_PINSET_BIT] : 1'b1;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q  <= 8'h00;
            size_q  <= 3'h0;
        end else begin
            wr_pend <= hsel && htrans[1] && hready && hwrite;
            rd_pend <= hsel && htrans[1] && hready && !hwrite;
            addr_q  <= haddr[7:0];
            size_q  <= hsize;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_ovf_set: assert property (rx_fifo_overflow |=> rx_fifo_overflow_flag)
        else $error("overflow flag not set after event");
    chk_bufna_set: assert property (rx_descriptor_overrun |=> rx_descriptor_unavailable_flag)
        else $error("descriptor flag not set after event");
    chk_ovf_fall: assert property ($fell(rx_fifo_overflow_flag) |-> $past(irq_wr))
        else $error("overflow flag fell without software write");
    chk_bufna_fall: assert property ($fell(rx_descriptor_unavailable_flag) |-> $past(irq_wr))
        else $error("descriptor flag fell without software write");
    chk_clear_one: assert property (clear_wr && hwdata[1] && !rx_descriptor_overrun |=> !rx_descriptor_unavailable_flag)
        else $error("clear alias did not clear descriptor flag");
    chk_clear_keep: assert property (clear_wr && !hwdata[0] && !rx_fifo_overflow
        |=> rx_fifo_overflow_flag == $past(rx_fifo_overflow_flag))
        else $error("clear alias changed a bit written zero");
    chk_sa_read: assert property (rd_pend && addr_q[7:4] == `ERF_GRP_SA && size_q == 3'h2
        |-> hrdata == {16'h0000, sa_now})
        else $error("station address read disagrees with octet outputs");
    chk_byte_ignore: assert property (wr_pend && addr_q[7:4] == `ERF_GRP_SA
        && size_q == `ERF_HSIZE_BYTE |=> $stable(sa_now))
        else $error("byte write changed station address");
    chk_boot_load: assert property ($past(hresetn) && !$past(hresetn, 2) |-> sa_now == $past(factory_station_addr)
        && phy_interface_select == $past(cfg_mii) && eth_pin_set_select == $past(cfg_pin))
        else $error("values after reset not loaded from fuses");
    chk_cfg_hold: assert property ($past(hresetn) && $past(hresetn, 2)
        |-> $stable(phy_interface_select) && $stable(eth_pin_set_select))
        else $error("interface selection changed outside reset");
    chk_bus_okay: assert property (hreadyout && hresp == `ERF_HRESP_OKAY)
        else $error("slave not ready or not okay");
endmodule

bind erf_top erf_checker #(.HAS_ALT_PINS(HAS_ALT_PINS)) u_erf_checker (.*);

// File: testbench.sv
// self-checking bench for the rx flag block over AHB-Lite
// assumes erf_top, its checker and erf_rx_source are compiled first
`timescale 1ns/10ps

module testbench;
    localparam logic [31:0] CFG0  = 32'hb7ff1234;
    localparam logic [31:0] CFG1  = 32'hb4ff1234;
    localparam logic [15:0] FADDR = 16'h5ac3;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, config_word_in, d;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2, hburst = 3'h0;
    logic [3:0]  hprot = 4'h0;
    logic        hreadyout, hresp, rx_descriptor_overrun, rx_fifo_overflow;
    logic        rx_descriptor_unavailable_flag, rx_fifo_overflow_flag;
    logic        phy_interface_select, eth_pin_set_select, rd_q = 1'b0;
    logic        ovf_req = 1'b0, dov_req = 1'b0, alt_cfg = 1'b0;
    logic [15:0] factory_station_addr;
    logic [7:0]  first_address_octet, second_address_octet;
    logic [31:0] expq[$];
    int          mismatches = 0, n_tests = 0, cycles = 0, seed = 85637;

    assign hready = hreadyout;
    erf_top       u_erf_top       (.*);
    erf_rx_source u_erf_rx_source (.*);
    always #2 hclk = ~hclk;

    // ****************************************************************
    // reporting and bus tasks
    // ****************************************************************
    task automatic give_verdict;
        $display("mismatches %0d, comparisons %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [2:0] sz,
                       input logic [31:0] wd, input logic [31:0] exp);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        hsize  <= sz;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        if (!wr) expq.push_back(exp);
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        ahb(1'b1, a, 3'h2, wd, 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 3'h2, 32'h0, exp);
    endtask
    task automatic pulse(input logic ovf);
        if (ovf) ovf_req <= 1'b1;
        else dov_req <= 1'b1;
        @(posedge hclk);
        ovf_req <= 1'b0;
        dov_req <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask
    task automatic do_reset(input logic alt);
        alt_cfg <= alt;
        hresetn <= 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
    endtask
    task automatic chk_boot(input logic [31:0] cfg, input logic [15:0] sa);
        cmp({30'h0, phy_interface_select, eth_pin_set_select}, {30'h0, cfg[24], cfg[25]});
        cmp({16'h0, second_address_octet, first_address_octet}, {16'h0, sa});
        rd(8'h20, cfg);
        rd(8'h10, {16'h0, sa});
    endtask

    // ****************************************************************
    // read monitor, timeout and main sequence
    // ****************************************************************
    always @(posedge hclk) begin
        if (rd_q) cmp(hrdata, expq.pop_front());
        rd_q = hresetn && hsel && htrans[1] && hready && !hwrite;
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            give_verdict;
        end
    end

    initial begin
        @(posedge hclk);
        do_reset(1'b0);
        chk_boot(CFG0, FADDR);
        rd(8'h00, 32'h0);
        pulse(1'b1);
        rd(8'h00, 32'h1);
        pulse(1'b0);
        rd(8'h00, 32'h3);
        wr(8'h04, 32'h0);
        rd(8'h00, 32'h3);
        wr(8'h04, 32'h2);
        rd(8'h00, 32'h1);
        wr(8'h04, 32'h1);
        rd(8'h00, 32'h0);
        wr(8'h08, 32'h3);
        rd(8'h00, 32'h3);
        wr(8'h0c, 32'h1);
        rd(8'h00, 32'h2);
        wr(8'h00, 32'h0);
        rd(8'h00, 32'h0);
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            wr(8'h10, {16'h0, d[15:0]});
            rd(8'h10, {16'h0, d[15:0]});
            cmp({16'h0, second_address_octet, first_address_octet}, {16'h0, d[15:0]});
        end
        ahb(1'b1, 8'h10, 3'h0, 32'hffffffff, 32'h0);
        rd(8'h10, {16'h0, d[15:0]});
        ahb(1'b1, 8'h18, 3'h1, 32'h0000f00f, 32'h0);
        rd(8'h10, {16'h0, d[15:0] | 16'hf00f});
        ahb(1'b1, 8'h14, 3'h1, 32'h0000ffff, 32'h0);
        rd(8'h10, 32'h0);
        ahb(1'b1, 8'h1c, 3'h2, 32'h0000a55a, 32'h0);
        ahb(1'b1, 8'h12, 3'h1, 32'hffff0000, 32'h0);
        rd(8'h10, 32'h0000a55a);
        ahb(1'b0, 8'h10, 3'h0, 32'h0, 32'h0);
        wr(8'h20, 32'h0);
        rd(8'h20, CFG0);
        rd(8'h40, 32'h0);
        do_reset(1'b1);
        chk_boot(CFG1, ~FADDR);
        // let the monitor take the last read before the verdict
        repeat (2) @(posedge hclk);
        give_verdict;
    end
endmodule
